// ===== hw/swm_pkg.sv
// package for the four channel scan word multiplexer
package swm_pkg;

  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned DATA_W     = 12;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned IND_W      = 4;
  localparam int unsigned IND_LSB    = 12;
  localparam logic [11:0] FULL_SCALE = 12'hfff;
  localparam logic [11:0] ZERO_SCALE = 12'h000;
  localparam logic [1:0]  FIRST_CH   = 2'h0;
  localparam logic [3:0]  IND_NONE   = 4'h0;
  localparam logic [15:0] WORD_RST   = 16'h0000;

  typedef logic [11:0] swm_sample_t;

  // one presented word: channel indicator on top, value below
  typedef struct packed {
    logic [3:0]  ind;
    swm_sample_t data;
  } swm_word_s;

  // one raw conversion as it arrives from the converter
  typedef struct packed {
    logic        valid;
    logic [1:0]  ch;
    swm_sample_t code;
  } swm_conv_s;

endpackage

// ===== hw/swm_latch.sv
// holding register for the latest conversion of each channel
`timescale 1ns/1ps
module swm_latch (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rstn_i,
  input  wire swm_pkg::swm_conv_s        conv_i,
  output      swm_pkg::swm_sample_t      hold_o [4]
);
  import swm_pkg::*;

  swm_sample_t hold_r   [NUM_CH];
  swm_sample_t hold_nxt [NUM_CH];

  // conversions land whenever they finish, independent of the scan
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_comb begin
        hold_nxt[g] = hold_r[g];
        if (conv_i.valid && (conv_i.ch == 2'(g))) begin
          hold_nxt[g] = conv_i.code;
        end
      end

      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          hold_r[g] <= ZERO_SCALE;
        end else begin
          hold_r[g] <= hold_nxt[g];
        end
      end

      assign hold_o[g] = hold_r[g];
    end
  endgenerate

endmodule

// ===== hw/swm_top.sv
// scan word multiplexer: presents one enabled channel per controller scan
//
// Summary of operation
// - one channel's data presented per scan
// - after last enabled, restart from first enabled channel
// - disabled channels are skipped entirely
// - word changes only on scan; conversion free
// - 12-bit unsigned value in low bits
// - word is sixteen input points wide
// - top four bits one-hot channel indicator, all zero when no channel is enabled
// - value spans 0 to 4095 full scale
`timescale 1ns/1ps
module swm_top (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  scan_i,
  input  wire logic [3:0]            ch_en_i,
  input  wire swm_pkg::swm_conv_s    conv_i,
  output      logic [15:0]           word_o,
  output      logic                  word_valid_o
);
  import swm_pkg::*;

  // ****************************************************************
  // per-channel conversion holding
  // ****************************************************************
  swm_sample_t hold [NUM_CH];

  swm_latch swm_latch_i (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .conv_i    (conv_i),
    .hold_o    (hold)
  );

  // ****************************************************************
  // channel selection
  // ****************************************************************
  typedef enum logic [0:0] { SWM_IDLE, SWM_RUN } swm_state_e;

  swm_state_e  state_r;
  swm_state_e  state_nxt;
  logic [1:0]  last_ch_r;
  logic [1:0]  last_ch_nxt;
  swm_word_s   word_r;
  swm_word_s   word_nxt;
  logic        valid_r;
  logic        valid_nxt;
  logic        found;
  logic [1:0]  pick;

  // search upward from the channel after the last one shown; going past
  // channel 4 wraps to channel 1, which is the restart after the last
  always_comb begin
    logic [1:0] cand;
    cand  = 2'h0;
    found = 1'b0;
    pick  = FIRST_CH;
    for (int k = 1; k <= NUM_CH; k++) begin
      cand = (state_r == SWM_IDLE) ? 2'(k - 1) : 2'(last_ch_r + 2'(k));
      if (!found && ch_en_i[cand]) begin
        found = 1'b1;
        pick  = cand;
      end
    end
  end

  always_comb begin
    state_nxt   = state_r;
    last_ch_nxt = last_ch_r;
    word_nxt    = word_r;
    valid_nxt   = valid_r;
    // update only on a scan; data and indicator loaded together
    if (scan_i) begin
      case (state_r)
        SWM_IDLE,
        SWM_RUN: begin
          if (found) begin
            state_nxt     = SWM_RUN;
            last_ch_nxt   = pick;
            word_nxt.ind  = 4'(4'h1 << pick);
            word_nxt.data = hold[pick];
            valid_nxt     = 1'b1;
          end else begin
            // nothing enabled: show an empty word with no indicator
            state_nxt     = SWM_IDLE;
            word_nxt.ind  = IND_NONE;
            word_nxt.data = ZERO_SCALE;
            valid_nxt     = 1'b0;
          end
        end
        default: begin
          state_nxt = SWM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r   <= SWM_IDLE;
      last_ch_r <= FIRST_CH;
      word_r    <= WORD_RST;
      valid_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      last_ch_r <= last_ch_nxt;
      word_r    <= word_nxt;
      valid_r   <= valid_nxt;
    end
  end

  assign word_o       = word_r;
  assign word_valid_o = valid_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_scan_pick;
    scan_i && found;
  endsequence

  sequence s_word_loaded;
    ##1 word_o[15:12] == $past(4'(4'h1 << pick));
  endsequence

  property p_indicator_onehot;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      valid_r |-> $onehot(word_o[15:12]);
  endproperty
  a_indicator_onehot: assert property (p_indicator_onehot) else $error("indicator not one-hot");

  property p_hold_between_scans;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      !scan_i |=> $stable(word_o);
  endproperty
  a_hold_between_scans: assert property (p_hold_between_scans) else $error("word changed without scan");

  property p_load_on_scan;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      s_scan_pick |-> s_word_loaded;
  endproperty
  a_load_on_scan: assert property (p_load_on_scan) else $error("picked channel not presented");

  // enables may drop between scans; judge against the enables of the scan itself
  property p_enabled_only;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      s_scan_pick |=> ((word_o[15:12] & $past(ch_en_i)) != 4'h0);
  endproperty
  a_enabled_only: assert property (p_enabled_only) else $error("disabled channel presented");

  property p_same_channel;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      s_scan_pick |=> word_o[11:0] == $past(hold[pick]);
  endproperty
  a_same_channel: assert property (p_same_channel) else $error("data mixed with other channel");

  property p_wrap_to_first;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (scan_i && found && state_r == SWM_RUN && ch_en_i[0] && last_ch_r == 2'h3) |=> word_o[15:12] == 4'h1;
  endproperty
  a_wrap_to_first: assert property (p_wrap_to_first) else $error("no restart at channel one");

  property p_alternate;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (scan_i && valid_r && ch_en_i == 4'h3 && word_o[15:12] == 4'h1) |=> word_o[15:12] == 4'h2;
  endproperty
  a_alternate: assert property (p_alternate) else $error("two channels not alternating");

  property p_empty_when_none;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (scan_i && ch_en_i == 4'h0) |=> (word_o == WORD_RST && !word_valid_o);
  endproperty
  a_empty_when_none: assert property (p_empty_when_none) else $error("word not cleared when none enabled");

endmodule

// ===== tb/swm_cpu_model.sv
// controller model: files each presented value under its channel
`timescale 1ns/1ps
module swm_cpu_model (
  input  wire logic        ref_clk_i,
  input  wire logic        scan_i,
  input  wire logic [15:0] word_i,
  input  wire logic        word_valid_i,
  output      logic [11:0] mem_o [4]
);
  logic scan_r;
  always @(posedge ref_clk_i) begin
    scan_r <= scan_i;
    // the word of the last scan has settled by now
    if (scan_r && word_valid_i) begin
      for (int k = 0; k < 4; k++) begin
        if (word_i[12+k]) begin
          mem_o[k] <= word_i[11:0];
        end
      end
    end
  end
endmodule

// ===== tb/swm_top_test.sv
// self-checking bench for the scan word multiplexer
`timescale 1ns/1ps
module swm_top_test;
  import swm_pkg::*;
  logic        clk = 0;
  logic        rstn = 0;
  logic        scan = 0;
  logic [3:0]  en = 4'hf;
  swm_conv_s   conv = '0;
  logic [15:0] word;
  logic        wv;
  logic [11:0] mem [4];
  int          errors = 0;
  int          checks = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  swm_top swm_top_i (.ref_clk_i(clk), .rstn_i(rstn), .scan_i(scan), .ch_en_i(en),
                     .conv_i(conv), .word_o(word), .word_valid_o(wv));
  swm_cpu_model swm_cpu_model_i (.ref_clk_i(clk), .scan_i(scan), .word_i(word),
                                 .word_valid_i(wv), .mem_o(mem));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic convert(input int ch, input logic [11:0] c);
    @(posedge clk) #1 conv = '{1'b1, ch[1:0], c};
    @(posedge clk) #1 conv.valid = 1'b0;
  endtask
  // one scan; returns with the new word settled
  task automatic scan_once;
    @(posedge clk) #1 scan = 1'b1;
    @(posedge clk) #1 scan = 1'b0;
  endtask
  task automatic see(input int ch, input logic [11:0] c);
    scan_once();
    check(word, {4'h1 << ch, c});
    check({15'h0, wv}, 16'h0001);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic all_four;
    convert(0, 12'h000);
    convert(1, 12'hfff);
    convert(2, 12'h400);
    convert(3, 12'h001);
    for (int k = 0; k < 4; k++) see(k, k == 0 ? 12'h000 : k == 1 ? 12'hfff : k == 2 ? 12'h400 : 12'h001);
    see(0, 12'h000);
    @(posedge clk) #1;
    check({4'h0, mem[3]}, 16'h0001);
    check({4'h0, mem[1]}, 16'h0fff);
  endtask
  task automatic alternate;
    en = 4'h3;
    see(1, 12'hfff);
    see(0, 12'h000);
    see(1, 12'hfff);
    en = 4'h5;
    see(2, 12'h400);
    see(0, 12'h000);
    see(2, 12'h400);
  endtask
  task automatic scan_locked;
    en = 4'hf;
    see(3, 12'h001);
    convert(3, 12'habc);
    convert(0, 12'h123);
    repeat (5) @(posedge clk);
    check(word, 16'h8001);
    see(0, 12'h123);
    see(1, 12'hfff);
    see(2, 12'h400);
    see(3, 12'habc);
  endtask
  task automatic none_enabled;
    en = 4'h0;
    scan_once();
    check(word, 16'h0000);
    check({15'h0, wv}, 16'h0000);
    en = 4'h2;
    see(1, 12'hfff);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    all_four();
    alternate();
    scan_locked();
    none_enabled();
    tally_and_finish();
  end
endmodule
